/* File: gpbk_pkg.sv */
package gpbk_pkg;

  // ************************************************************
  // Bank layout
  // ************************************************************
  localparam int GPBK_NPORT = 10;
  localparam int GPBK_W = 8;

  // Register kinds reached through the plain command port.
  typedef enum logic [1:0] {
    GPBK_KIND_DATA = 2'h0,
    GPBK_KIND_DIR = 2'h1,
    GPBK_KIND_PULL = 2'h2
  } gpbk_kind_t;

  // Port number carried by each slot of the pin vectors.
  localparam logic [3:0] GPBK_PORT_NUM [GPBK_NPORT] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'he
  };
  localparam logic [3:0] GPBK_PORT13_NUM = 4'hd;

  // Slots that alternate functions use: 4 to 6 are overridden, 2 and 7 only read.
  localparam int GPBK_SLOT_P4 = 4;
  localparam int GPBK_SLOT_P5 = 5;
  localparam int GPBK_SLOT_P6 = 6;
  localparam int GPBK_SLOT_P7 = 7;
  localparam int GPBK_SLOT_P2 = 2;

  // Pins that exist on each port.
  localparam logic [7:0] GPBK_PIN_MASK [GPBK_NPORT] = '{
    8'h7f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h3f
  };
  // Pins with an output latch and a direction bit.
  localparam logic [7:0] GPBK_IO_MASK [GPBK_NPORT] = '{
    8'h7f, 8'hff, 8'h00, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h3f
  };
  // Pins with a selectable pull-up.
  localparam logic [7:0] GPBK_PU_MASK [GPBK_NPORT] = '{
    8'h7f, 8'hff, 8'h00, 8'h0f, 8'hff, 8'hff, 8'hf0, 8'hff, 8'h01, 8'h3f
  };
  // Pins driven open-drain.
  localparam logic [7:0] GPBK_OD_MASK [GPBK_NPORT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00
  };

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] GPBK_DIR_RST = 8'hff;
  localparam logic [7:0] GPBK_LAT_RST = 8'h00;
  localparam logic [7:0] GPBK_PU_RST = 8'h00;
  localparam logic GPBK_P13_RST = 1'b0;
  localparam logic [2:0] GPBK_SYNC_RST = 3'h0;
  localparam logic [7:0] GPBK_RDATA_RST = 8'h00;

endpackage

/* File: gpbk_port_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface gpbk_port_if;
  logic wr_data;
  logic wr_dir;
  logic wr_pull;
  logic [7:0] wdata;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] pull_en;
  logic [7:0] dir;
  logic [7:0] pu;
  logic [7:0] data_rd;
  logic [7:0] level;

  modport bank (
    output wr_data, wr_dir, wr_pull, wdata, pin_in,
    input pin_out, pin_oe, pull_en, dir, pu, data_rd, level
  );
  modport port (
    input wr_data, wr_dir, wr_pull, wdata, pin_in,
    output pin_out, pin_oe, pull_en, dir, pu, data_rd, level
  );
endinterface

`default_nettype wire

/* File: gpbk_port.sv */
`timescale 1ns/1ps
`default_nettype none

module gpbk_port
  import gpbk_pkg::*;
#(
  parameter logic [7:0] PIN_MASK = 8'hff,
  parameter logic [7:0] IO_MASK = 8'hff,
  parameter logic [7:0] PU_MASK = 8'hff,
  parameter logic [7:0] OD_MASK = 8'h00
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  gpbk_port_if.port p
);

  logic [7:0] dir_q, lat_q, pu_q, lvl_q;
  logic [7:0] s1_q, s2_q, s3_q;
  wire [7:0] agree = ~(s2_q ^ s3_q);
  wire [7:0] outmode = ~dir_q & IO_MASK;

  // ************************************************************
  // Pin sampling
  // ************************************************************
  // A pin level is taken only once two late stages agree.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q <= GPBK_LAT_RST;
      s2_q <= GPBK_LAT_RST;
      s3_q <= GPBK_LAT_RST;
      lvl_q <= GPBK_LAT_RST;
    end else begin
      s1_q <= p.pin_in & PIN_MASK;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (agree & s3_q) | (~agree & lvl_q);
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  // Unimplemented direction bits hold one and read back as one.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      dir_q <= GPBK_DIR_RST; // [RULE3] [RULE18]
      lat_q <= GPBK_LAT_RST;
      pu_q <= GPBK_PU_RST;
    end else begin
      if (p.wr_dir) begin
        dir_q <= (p.wdata & IO_MASK) | ~IO_MASK; // [RULE1] [RULE17]
      end
      if (p.wr_data) begin
        lat_q <= p.wdata & IO_MASK; // [RULE19]
      end
      if (p.wr_pull) begin
        pu_q <= p.wdata & PU_MASK; // [RULE9]
      end
    end
  end

  // ************************************************************
  // Pin drive and read-back
  // ************************************************************
  // Open-drain bits only ever pull low; a one releases the pin.
  assign p.pin_oe = (outmode & ~OD_MASK) |
                    (outmode & OD_MASK & ~lat_q); // [RULE10] [RULE17]
  assign p.pin_out = lat_q & ~OD_MASK;
  assign p.pull_en = pu_q & dir_q & PU_MASK; // [RULE2] [RULE20]
  assign p.data_rd = ((dir_q & lvl_q) | (~dir_q & lat_q))
                     & PIN_MASK; // [RULE19]
  assign p.dir = dir_q;
  assign p.pu = pu_q;
  assign p.level = lvl_q;

endmodule // gpbk_port

`default_nettype wire

/* File: gpbk_bank.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1: Port 0: seven pins, per-bit direction, latch.
// RULE2: Port 0 pull-up only in input mode.
// RULE3: Reset makes all port 0 pins inputs.
// RULE4: Port 1: eight I/O pins, reset inputs.
// RULE5: Port 2: eight input-only pins, feed analog.
// RULE6: Port 3: four I/O pins, reset inputs.
// RULE7: Port 4 carries address/data in expansion mode.
// RULE8: Port 5 outputs upper address in expansion.
// RULE9: Port 6 pull-ups on upper four only.
// RULE10: Port 6 lower four pins open-drain.
// RULE11: Port 6 upper four are expansion strobes.
// RULE12: Software idles serial B before port 0.
// RULE13: Software idles serial A before port 1.
// RULE14: Port 13 is one output-only pin.
// RULE15: Port 14: six I/O pins, reset inputs.
// RULE16: Sixty-seven pins, fifty-four with pull-ups.
// RULE17: Direction zero drives, one makes input.
// RULE18: Reset loads direction registers with ones.
// RULE19: Reads give pin or latch; writes latch.
// RULE20: Pull-up ignored while bit is output.
module gpbk_bank
  import gpbk_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_port,
  input wire logic [1:0] i_reg_kind,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire logic [GPBK_NPORT-1:0][7:0] i_pin_in,
  output logic [GPBK_NPORT-1:0][7:0] o_pin_out,
  output logic [GPBK_NPORT-1:0][7:0] o_pin_oe,
  output logic [GPBK_NPORT-1:0][7:0] o_pin_pullup,
  output logic o_port13_out,
  output logic [7:0] o_adc_in,
  output logic [7:0] o_key_return_inputs,
  input wire logic i_ext_mem_mode,
  input wire logic [7:0] i_ext_ad_out,
  input wire logic i_ext_ad_oe,
  output logic [7:0] o_ext_ad_in,
  input wire logic [7:0] i_ext_addr_hi,
  input wire logic [3:0] i_ext_strobe
);

  // ************************************************************
  // Command decode
  // ************************************************************
  wire kind_data = (i_reg_kind == GPBK_KIND_DATA);
  wire kind_dir = (i_reg_kind == GPBK_KIND_DIR);
  wire kind_pull = (i_reg_kind == GPBK_KIND_PULL);
  wire p13_hit = (i_reg_port == GPBK_PORT13_NUM);

  gpbk_port_if pif [GPBK_NPORT] ();

  logic [GPBK_NPORT-1:0][7:0] rd_data, rd_dir, rd_pu;
  logic [GPBK_NPORT-1:0] hit;
  logic [GPBK_NPORT-1:0][7:0] base_out, base_oe, base_pull;

  // ************************************************************
  // Port slots
  // ************************************************************
  // Widths and pull-up sets per slot give 66 pins, 54 pull-ups; port 13 is the 67th pin.
  genvar g;
  generate
    for (g = 0; g < GPBK_NPORT; g++) begin : g_port
      assign hit[g] = (i_reg_port == GPBK_PORT_NUM[g]);
      assign pif[g].wr_data = i_reg_wr & hit[g] & kind_data; // [RULE19]
      assign pif[g].wr_dir = i_reg_wr & hit[g] & kind_dir;
      assign pif[g].wr_pull = i_reg_wr & hit[g] & kind_pull;
      assign pif[g].wdata = i_reg_wdata;
      assign pif[g].pin_in = i_pin_in[g];
      assign rd_data[g] = pif[g].data_rd;
      assign rd_dir[g] = pif[g].dir;
      assign rd_pu[g] = pif[g].pu;
      assign base_out[g] = pif[g].pin_out;
      assign base_oe[g] = pif[g].pin_oe;
      assign base_pull[g] = pif[g].pull_en;

      gpbk_port #(
        .PIN_MASK(GPBK_PIN_MASK[g]),
        .IO_MASK(GPBK_IO_MASK[g]),
        .PU_MASK(GPBK_PU_MASK[g]),
        .OD_MASK(GPBK_OD_MASK[g])
      ) u_port (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .p(pif[g])
      ); // [RULE1] [RULE4] [RULE6] [RULE15] [RULE16]
    end
  endgenerate

  // ************************************************************
  // Expansion-mode overrides
  // ************************************************************
  // The memory interface owns ports 4, 5 and the top of port 6 while
  // expansion mode is on; their latches keep their contents meanwhile.
  wire [7:0] p4_oe = i_ext_mem_mode ? {8{i_ext_ad_oe}}
                                    : base_oe[GPBK_SLOT_P4]; // [RULE7]
  wire [7:0] p4_out = i_ext_mem_mode ? i_ext_ad_out
                                     : base_out[GPBK_SLOT_P4]; // [RULE7]
  wire [7:0] p4_pull = base_pull[GPBK_SLOT_P4] & ~p4_oe; // [RULE20]
  wire [7:0] p5_oe = i_ext_mem_mode ? 8'hff
                                    : base_oe[GPBK_SLOT_P5]; // [RULE8]
  wire [7:0] p5_out = i_ext_mem_mode ? i_ext_addr_hi
                                     : base_out[GPBK_SLOT_P5]; // [RULE8]
  wire [7:0] p5_pull = base_pull[GPBK_SLOT_P5] & ~p5_oe; // [RULE20]
  wire [7:0] p6_oe = i_ext_mem_mode
                     ? {4'hf, base_oe[GPBK_SLOT_P6][3:0]}
                     : base_oe[GPBK_SLOT_P6]; // [RULE11]
  wire [7:0] p6_out = i_ext_mem_mode
                      ? {i_ext_strobe, base_out[GPBK_SLOT_P6][3:0]}
                      : base_out[GPBK_SLOT_P6]; // [RULE11]
  wire [7:0] p6_pull = base_pull[GPBK_SLOT_P6] & ~p6_oe; // [RULE9]

  always_comb begin
    o_pin_out = base_out;
    o_pin_oe = base_oe;
    o_pin_pullup = base_pull;
    o_pin_out[GPBK_SLOT_P4] = p4_out;
    o_pin_oe[GPBK_SLOT_P4] = p4_oe;
    o_pin_pullup[GPBK_SLOT_P4] = p4_pull;
    o_pin_out[GPBK_SLOT_P5] = p5_out;
    o_pin_oe[GPBK_SLOT_P5] = p5_oe;
    o_pin_pullup[GPBK_SLOT_P5] = p5_pull;
    o_pin_out[GPBK_SLOT_P6] = p6_out;
    o_pin_oe[GPBK_SLOT_P6] = p6_oe;
    o_pin_pullup[GPBK_SLOT_P6] = p6_pull;
  end

  // Bus read data and analog inputs see the filtered pin levels.
  assign o_ext_ad_in = pif[GPBK_SLOT_P4].level;
  assign o_adc_in = pif[GPBK_SLOT_P2].level; // [RULE5]
  assign o_key_return_inputs = pif[GPBK_SLOT_P7].level;

  // ************************************************************
  // Port 13
  // ************************************************************
  // Output-only: no direction bit, and it drives low out of reset.
  logic p13_q;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p13_q <= GPBK_P13_RST; // [RULE14]
    end else if (i_reg_wr & p13_hit & kind_data) begin
      p13_q <= i_reg_wdata[0]; // [RULE14]
    end
  end
  assign o_port13_out = p13_q;

  // ************************************************************
  // Read-back
  // ************************************************************
  // Port 13 reads its latch, and an unmapped port number reads zero.
  logic [7:0] sel_data, sel_dir, sel_pu, rdata_d;
  always_comb begin
    sel_data = p13_hit ? {7'h00, p13_q} : 8'h00;
    sel_dir = 8'h00;
    sel_pu = 8'h00;
    for (int i = 0; i < GPBK_NPORT; i++) begin
      if (hit[i]) begin
        sel_data = rd_data[i]; // [RULE19]
        sel_dir = rd_dir[i];
        sel_pu = rd_pu[i];
      end
    end
    rdata_d = kind_data ? sel_data :
              kind_dir ? sel_dir :
              kind_pull ? sel_pu : 8'h00;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= GPBK_RDATA_RST;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_d;
      end
    end
  end

endmodule // gpbk_bank

`default_nettype wire

/* File: gpbk_bank_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ******
// Pin bank checks.
// ******
module gpbk_bank_asserts
  import gpbk_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [3:0] i_reg_port,
  input wire logic [1:0] i_reg_kind,
  input wire logic [7:0] i_reg_wdata,
  input wire logic o_reg_rvalid,
  input wire logic [GPBK_NPORT-1:0][7:0] o_pin_out,
  input wire logic [GPBK_NPORT-1:0][7:0] o_pin_oe,
  input wire logic [GPBK_NPORT-1:0][7:0] o_pin_pullup,
  input wire logic o_port13_out,
  input wire logic i_ext_mem_mode,
  input wire logic [7:0] i_ext_ad_out,
  input wire logic i_ext_ad_oe,
  input wire logic [7:0] i_ext_addr_hi,
  input wire logic [3:0] i_ext_strobe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence s_dir1_wr;
    i_reg_wr && i_reg_port == 4'h1 && i_reg_kind == 2'h1;
  endsequence
  property p_rd_ans; i_reg_rd |=> o_reg_rvalid; endproperty
  property p_dir_oe;
    s_dir1_wr |=> o_pin_oe[1] == ~$past(i_reg_wdata);
  endproperty
  property p_pull_off; (o_pin_oe & o_pin_pullup) == '0; endproperty
  // Missing pins must never be driven, or they would fight the pad ring.
  property p_no_pin;
    o_pin_oe[2] == 8'h00 && o_pin_oe[0][7] == 1'b0 &&
      o_pin_oe[3][7:4] == 4'h0 && o_pin_oe[9][7:6] == 2'h0;
  endproperty
  property p_p6_low;
    o_pin_out[6][3:0] == 4'h0 && o_pin_pullup[6][3:0] == 4'h0;
  endproperty
  property p_ext4;
    i_ext_mem_mode |-> o_pin_oe[4] == {8{i_ext_ad_oe}} &&
      o_pin_out[4] == i_ext_ad_out;
  endproperty
  property p_ext5;
    i_ext_mem_mode |-> o_pin_oe[5] == 8'hff && o_pin_out[5] == i_ext_addr_hi;
  endproperty
  property p_ext6;
    i_ext_mem_mode |-> o_pin_oe[6][7:4] == 4'hf &&
      o_pin_out[6][7:4] == i_ext_strobe;
  endproperty
  property p_rst;
    $rose(i_reset_n) |-> o_pin_oe == '0 && !o_port13_out;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no rvalid");
  a_dir_oe: assert property (p_dir_oe) else $error("dir oe");
  a_pull_off: assert property (p_pull_off) else $error("pull");
  a_no_pin: assert property (p_no_pin) else $error("pins");
  a_p6_low: assert property (p_p6_low) else $error("p6 low");
  a_ext4: assert property (p_ext4) else $error("ext p4");
  a_ext5: assert property (p_ext5) else $error("ext p5");
  a_ext6: assert property (p_ext6) else $error("ext p6");
  a_rst: assert property (p_rst) else $error("reset");
endmodule // gpbk_bank_asserts

bind gpbk_bank gpbk_bank_asserts chk_u (.i_mclk, .i_reset_n, .i_reg_wr,
  .i_reg_rd, .i_reg_port, .i_reg_kind, .i_reg_wdata, .o_reg_rvalid,
  .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_port13_out, .i_ext_mem_mode,
  .i_ext_ad_out, .i_ext_ad_oe, .i_ext_addr_hi, .i_ext_strobe);
`default_nettype wire

/* File: gpbk_pins_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ******
// Pads: an undriven pin without pull-up toggles every cycle, so that a
// floating line never passes the level filter and the read level holds.
// ******
module gpbk_pins_model
  import gpbk_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [GPBK_NPORT-1:0][7:0] i_out,
  input wire logic [GPBK_NPORT-1:0][7:0] i_oe,
  input wire logic [GPBK_NPORT-1:0][7:0] i_pu,
  input wire logic [GPBK_NPORT-1:0][7:0] i_ext,
  input wire logic [GPBK_NPORT-1:0][7:0] i_ext_en,
  output logic [GPBK_NPORT-1:0][7:0] o_lvl
);
  // Serial channels on ports 0 and 1 are never driven here, so software
  // is taken to keep them idle and those pins act as plain port pins.
  logic flip_q = 1'b0;
  always @(posedge i_mclk) flip_q <= ~flip_q;
  assign o_lvl = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) |
    (~i_oe & ~i_ext_en & (i_pu | {80{flip_q}}));
endmodule // gpbk_pins_model
`default_nettype wire

/* File: gpbk_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ******
// Reads queue their expected data; a monitor checks each answer.
// ******
module gpbk_bank_tb
  import gpbk_pkg::*;
;
  logic i_mclk = 1'b0, i_reset_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic [3:0] i_reg_port = 4'h0, i_ext_strobe = 4'h0;
  logic [1:0] i_reg_kind = 2'h0;
  logic [7:0] i_reg_wdata = 8'h00, i_ext_ad_out = 8'h00;
  logic [7:0] i_ext_addr_hi = 8'h00, o_reg_rdata, o_adc_in, o_ext_ad_in;
  logic i_ext_mem_mode = 1'b0, i_ext_ad_oe = 1'b0, o_reg_rvalid;
  logic o_port13_out;
  logic [7:0] o_key_return_inputs, d, m, p, e, q[$];
  logic [GPBK_NPORT-1:0][7:0] i_pin_in, o_pin_out, o_pin_oe, o_pin_pullup;
  logic [GPBK_NPORT-1:0][7:0] ext_val = '0, ext_en = '1, oe_x;
  int errors = 0, checks_done = 0, seed = 32'h169da02b;
  gpbk_bank dut_u (.i_mclk, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_port,
    .i_reg_kind, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_pin_in,
    .o_pin_out, .o_pin_oe, .o_pin_pullup, .o_port13_out, .o_adc_in,
    .o_key_return_inputs, .i_ext_mem_mode, .i_ext_ad_out, .i_ext_ad_oe,
    .o_ext_ad_in, .i_ext_addr_hi, .i_ext_strobe);
  gpbk_pins_model pads_u (.i_mclk, .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pu(o_pin_pullup), .i_ext(ext_val), .i_ext_en(ext_en), .o_lvl(i_pin_in));
  always #2 i_mclk = ~i_mclk;
  task chk(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Each strobe is held across back-to-back calls until a call passes it as zero.
  task op(input logic w, input logic r, input logic [3:0] pt,
    input logic [1:0] k, input logic [7:0] wd, input logic [7:0] x);
    i_reg_wr <= w;
    i_reg_rd <= r;
    i_reg_port <= pt;
    i_reg_kind <= k;
    i_reg_wdata <= wd;
    if (r) q.push_back(x);
    @(posedge i_mclk);
  endtask
  task do_reset;
    i_reset_n <= 1'b0;
    repeat (20) @(posedge i_mclk);
    i_reset_n <= 1'b1;
  endtask
  task finish_test;
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    if (o_reg_rvalid === 1'b1) begin
      chk(o_reg_rdata, q.pop_front());
    end
  end
  initial begin
    #40000;
    errors++;
    finish_test();
  end
  initial begin
    do_reset();
    chk(o_pin_oe, '0);
    chk(o_port13_out, 1'b0);
    for (int s = 0; s < GPBK_NPORT; s++) begin
      op(1'b0, 1'b1, GPBK_PORT_NUM[s], 2'h1, 8'h00, 8'hff);
      op(1'b0, 1'b1, GPBK_PORT_NUM[s], 2'h2, 8'h00, 8'h00);
    end
    op(1'b0, 1'b1, 4'h8, 2'h0, 8'h00, 8'h00);
    op(1'b0, 1'b1, 4'h1, 2'h3, 8'h00, 8'h00);
    for (int s = 0; s < GPBK_NPORT; s++) begin
      d = 8'($random(seed));
      m = 8'($random(seed));
      p = 8'($random(seed));
      e = 8'($random(seed));
      ext_val[s] <= e;
      op(1'b1, 1'b0, GPBK_PORT_NUM[s], 2'h0, d, 8'h00);
      op(1'b1, 1'b0, GPBK_PORT_NUM[s], 2'h1, m, 8'h00);
      op(1'b1, 1'b0, GPBK_PORT_NUM[s], 2'h2, p, 8'h00);
      op(1'b0, 1'b0, 4'h0, 2'h0, 8'h00, 8'h00);
      repeat (6) @(posedge i_mclk);
      m = m | ~GPBK_IO_MASK[s];
      oe_x[s] = ~m & ~(d & GPBK_OD_MASK[s]);
      chk(o_pin_oe[s], oe_x[s]);
      chk(o_pin_pullup[s], p & m & GPBK_PU_MASK[s]);
      chk(o_pin_out[s] & oe_x[s], d & oe_x[s] & ~GPBK_OD_MASK[s]);
      e = ((m & e) | (~m & d)) & GPBK_PIN_MASK[s];
      op(1'b0, 1'b1, GPBK_PORT_NUM[s], 2'h0, 8'h00, e);
      op(1'b0, 1'b1, GPBK_PORT_NUM[s], 2'h1, 8'h00, m);
      p = p & GPBK_PU_MASK[s];
      op(1'b0, 1'b1, GPBK_PORT_NUM[s], 2'h2, 8'h00, p);
      op(1'b0, 1'b0, 4'h0, 2'h0, 8'h00, 8'h00);
    end
    chk(o_adc_in, ext_val[2]);
    op(1'b1, 1'b0, GPBK_PORT13_NUM, 2'h0, 8'h01, 8'h00);
    op(1'b0, 1'b1, GPBK_PORT13_NUM, 2'h1, 8'h00, 8'h00);
    op(1'b0, 1'b0, 4'h0, 2'h0, 8'h00, 8'h00);
    chk(o_port13_out, 1'b1);
    i_ext_ad_out <= 8'($random(seed));
    i_ext_addr_hi <= 8'($random(seed));
    i_ext_strobe <= 4'($random(seed));
    i_ext_mem_mode <= 1'b1;
    repeat (6) @(posedge i_mclk);
    chk(o_pin_out[5], i_ext_addr_hi);
    chk(o_ext_ad_in, ext_val[4]);
    i_ext_ad_oe <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk(o_pin_oe[4], 8'hff);
    chk(o_pin_out[6][7:4], i_ext_strobe);
    i_ext_mem_mode <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk(o_pin_oe, oe_x);
    do_reset();
    chk(o_pin_oe, '0);
    op(1'b0, 1'b1, 4'h5, 2'h1, 8'h00, 8'hff);
    op(1'b0, 1'b1, 4'h6, 2'h2, 8'h00, 8'h00);
    op(1'b0, 1'b0, 4'h0, 2'h0, 8'h00, 8'h00);
    repeat (4) @(posedge i_mclk);
    chk(o_key_return_inputs, ext_val[7]);
    // Let port 7 float; only its pull-ups may then set the level.
    ext_en[7] <= 8'h00;
    op(1'b1, 1'b0, 4'h7, 2'h2, 8'hff, 8'h00);
    op(1'b0, 1'b0, 4'h0, 2'h0, 8'h00, 8'h00);
    repeat (6) @(posedge i_mclk);
    chk(o_pin_pullup[7], 8'hff);
    chk(o_key_return_inputs, 8'hff);
    chk(q.size(), 0);
    finish_test();
  end
endmodule // gpbk_bank_tb
`default_nettype wire
